//--- include/codec_ctrl_cfg.svh
// register indices, field positions and reset values of the codec
// control bank; definitions only, included by the design file
`ifndef CODEC_CTRL_CFG_SVH
`define CODEC_CTRL_CFG_SVH

// bus address: word index sits above the byte lanes
`define ADR_RANGE 9:0
`define IDX_RANGE 9:2
`define LOW_BYTE 7:0
`define HIGH_BYTE 15:8
`define COEF_RANGE 15:0
`define CHAN_FIELD 3:0
`define LANE_LO 0
`define LANE_HI 1

// register indices; byte address is four times the index
`define IDX_CHAN_EN 8'h4A
`define IDX_RT_PEEK 8'h4D
`define IDX_RT_CLEAR 8'h4F
`define IDX_PIN_DATA 8'h52
`define IDX_PIN_DIR 8'h54
`define IDX_OP_FUNC 8'h60
`define IDX_IRQ_MASK 8'h6C
`define IDX_OP_COND 8'h70
`define IDX_REVISION 8'h73
`define IDX_TX_GAIN 8'h80
`define IDX_RX_GAIN 8'h82

// pin direction / status fields
`define PIN_FIELD 4:0
`define DIR_FSL_BIT 5
`define DIR_ACT_BIT 6

// coding and filter source fields
`define OF_LINEAR 7
`define OF_MULAW 6
`define OF_RXG 5
`define OF_TXG 4
`define OF_XEQ 3
`define OF_REQ 2
`define OF_IMP 1
`define OF_BAL 0

// operating condition fields
`define OC_TX_CUT 7
`define OC_RX_CUT 6
`define OC_HPF_BYP 5
`define OC_RX_LOSS 4
`define OC_TX_ARM 3
`define OC_SLOT_LB 2
`define OC_DIG_LB 1
`define OC_TONE 0

// sign bit of each sign/exponent pair, highest pair first
`define SIGN_P4 15
`define SIGN_P3 11
`define SIGN_P2 7
`define SIGN_P1 3

// reset values and built-in default coefficients
`define RST_CHAN_EN 4'hF
`define RST_BYTE 8'h00
`define RST_PINS 5'h00
`define RST_IRQ_MASK 8'hFF
`define TX_GAIN_ROM 16'hA9F0
`define RX_GAIN_ROM 16'h23A1
`define RST_WORD 32'h0000_0000

`endif

//--- include/codec_ctrl_pkg.sv
// types shared by the codec control bank
// no dependencies
package codec_ctrl_pkg;

  typedef enum logic {BUS_IDLE, BUS_ACK} bus_state_e;

endpackage : codec_ctrl_pkg

//--- design/codec_channel_control_regs.sv
// per-channel control and status registers of a four-channel codec
// assumes a classic Wishbone master on core_clk, inputs synchronous
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "codec_ctrl_cfg.svh"

module codec_channel_control_regs
#(
  parameter int PINS_AVAIL = 5,
  // value is arbitrary
  parameter logic [7:0] REVISION_CODE = 8'h3C
)
(
  input logic core_clk,
  input logic nrst,
  input logic ce,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [`ADR_RANGE] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic [3:0] channelActive,
  input logic frameSyncLost,
  input logic [7:0] realTimeIn,
  input logic [19:0] lineIoIn,
  output logic [19:0] lineIoOut,
  output logic [19:0] lineIoOeN,
  output logic inputChangeIrqN,
  output logic [3:0] linearCoding,
  output logic [3:0] muLawCoding,
  output logic [3:0] rxGainSrc,
  output logic [3:0] txGainSrc,
  output logic [3:0] transmitEqSrc,
  output logic [3:0] receiveEqSrc,
  output logic [3:0] impedanceSrc,
  output logic [3:0] balanceSrc,
  output logic [3:0] balanceFilterEn,
  output logic [3:0] txPathCutoff,
  output logic [3:0] rxPathCutoff,
  output logic [3:0] txHighpassBypass,
  output logic [3:0] rxExtraLoss,
  output logic [3:0] txIrqArm,
  output logic [3:0] slotLoopback,
  output logic [3:0] digitalLoopback,
  output logic [3:0] rxTestTone,
  output logic [63:0] txGainCoef,
  output logic [63:0] rxGainCoef,
  output logic [15:0] txGainSignNeg,
  output logic [15:0] rxGainSignNeg
);

  localparam int CHANS = 4;
  localparam int LINE_PINS = 5;
  localparam int COEF_W = 16;
  localparam int SIGNS = 4;

  ////////////////////////////////////////////////////////////////////
  // decoding helpers

  // lowest enabled channel answers reads
  function automatic logic [1:0] firstEnabled(input logic [3:0] en);
    logic [1:0] pick;
    pick = 2'h3;
    for (int i = CHANS - 1; i >= 0; i--)
    begin
      if (en[i])
        pick = 2'(i);
    end
    return pick;
  endfunction : firstEnabled

  // sign bits of the four pairs: 1 means a -1 multiplier
  function automatic logic [3:0] signsOf(input logic [15:0] coef);
    return {coef[`SIGN_P4], coef[`SIGN_P3],
            coef[`SIGN_P2], coef[`SIGN_P1]};
  endfunction : signsOf

  ////////////////////////////////////////////////////////////////////
  // state

  codec_ctrl_pkg::bus_state_e busState_reg;
  codec_ctrl_pkg::bus_state_e busState_next;
  logic ack_reg;
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;
  logic [3:0] chanEnable_reg;
  logic [CHANS-1:0][LINE_PINS-1:0] pinDir_reg;
  logic [CHANS-1:0][LINE_PINS-1:0] pinData_reg;
  logic [CHANS-1:0][7:0] opFunc_reg;
  logic [CHANS-1:0][7:0] opCond_reg;
  logic [CHANS-1:0][COEF_W-1:0] txCoef_reg;
  logic [CHANS-1:0][COEF_W-1:0] rxCoef_reg;
  logic [7:0] irqMask_reg;
  logic [7:0] pending_reg;
  logic [7:0] pending_next;
  logic [7:0] rtPrev_reg;

  ////////////////////////////////////////////////////////////////////
  // bus decode

  wire [7:0] wbIdx = wb_adr_i[`IDX_RANGE];
  wire [7:0] wbLo = wb_dat_i[`LOW_BYTE];
  wire [7:0] wbHi = wb_dat_i[`HIGH_BYTE];
  wire laneLo = wb_sel_i[`LANE_LO];
  wire laneHi = wb_sel_i[`LANE_HI];
  wire idle = busState_reg == codec_ctrl_pkg::BUS_IDLE;
  wire req = ce && wb_cyc_i && wb_stb_i && idle;
  wire wrStrobe = req && wb_we_i;
  wire rdStrobe = req && !wb_we_i;
  wire anyEn = |chanEnable_reg;
  wire [1:0] rdCh = firstEnabled(chanEnable_reg);
  wire wrDir = wrStrobe && wbIdx == `IDX_PIN_DIR;
  wire wrData = wrStrobe && wbIdx == `IDX_PIN_DATA;
  wire wrFunc = wrStrobe && wbIdx == `IDX_OP_FUNC;
  wire wrCond = wrStrobe && wbIdx == `IDX_OP_COND;
  wire wrTx = wrStrobe && wbIdx == `IDX_TX_GAIN;
  wire wrRx = wrStrobe && wbIdx == `IDX_RX_GAIN;
  wire wrMask = wrStrobe && wbIdx == `IDX_IRQ_MASK && laneLo;
  wire wrEnable = wrStrobe && wbIdx == `IDX_CHAN_EN && laneLo;
  wire clrPend = rdStrobe && wbIdx == `IDX_RT_CLEAR;

  // pin levels for reads: driven data on outputs, pad on inputs
  wire [LINE_PINS-1:0] selDir = pinDir_reg[rdCh];
  wire [LINE_PINS-1:0] selPad = lineIoIn[rdCh*LINE_PINS +: LINE_PINS];
  wire [LINE_PINS-1:0] pinLevel =
    (selDir & pinData_reg[rdCh]) | (~selDir & selPad);

  // masked inputs never raise an event; a set beats a clear
  wire [7:0] change = (realTimeIn ^ rtPrev_reg) & ~irqMask_reg;
  assign pending_next = (pending_reg & ~{8{clrPend}}) | change;

  ////////////////////////////////////////////////////////////////////
  // bus handshake

  always_comb
  begin
    case (busState_reg)
      codec_ctrl_pkg::BUS_IDLE:
        busState_next = req ? codec_ctrl_pkg::BUS_ACK
                            : codec_ctrl_pkg::BUS_IDLE;
      codec_ctrl_pkg::BUS_ACK:
        busState_next = codec_ctrl_pkg::BUS_IDLE;
      default:
        busState_next = codec_ctrl_pkg::BUS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busState_reg <= codec_ctrl_pkg::BUS_IDLE;
      ack_reg <= 1'b0;
      rdData_reg <= `RST_WORD;
    end
    else if (ce)
    begin
      busState_reg <= busState_next;
      ack_reg <= req;
      rdData_reg <= rdStrobe ? rdData_next : `RST_WORD;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

  ////////////////////////////////////////////////////////////////////
  // read mux

  always_comb
  begin
    rdData_next = `RST_WORD;
    case (wbIdx)
      `IDX_CHAN_EN:
        rdData_next[`CHAN_FIELD] = chanEnable_reg;
      `IDX_RT_PEEK, `IDX_RT_CLEAR:
        rdData_next[`LOW_BYTE] = realTimeIn;
      `IDX_IRQ_MASK:
        rdData_next[`LOW_BYTE] = irqMask_reg;
      `IDX_REVISION:
        rdData_next[`LOW_BYTE] = REVISION_CODE;
      `IDX_PIN_DIR:
      begin
        rdData_next[`DIR_FSL_BIT] = frameSyncLost;
        if (anyEn)
        begin
          rdData_next[`PIN_FIELD] = selDir;
          rdData_next[`DIR_ACT_BIT] = channelActive[rdCh];
        end
      end
      `IDX_PIN_DATA:
        if (anyEn)
          rdData_next[`PIN_FIELD] = pinLevel;
      `IDX_OP_FUNC:
        if (anyEn)
          rdData_next[`LOW_BYTE] = opFunc_reg[rdCh];
      `IDX_OP_COND:
        if (anyEn)
          rdData_next[`LOW_BYTE] = opCond_reg[rdCh];
      `IDX_TX_GAIN:
        if (anyEn)
          rdData_next[`COEF_RANGE] = txCoef_reg[rdCh];
      `IDX_RX_GAIN:
        if (anyEn)
          rdData_next[`COEF_RANGE] = rxCoef_reg[rdCh];
      default:
        rdData_next = `RST_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // global registers

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      chanEnable_reg <= `RST_CHAN_EN;
      irqMask_reg <= `RST_IRQ_MASK;
      pending_reg <= `RST_BYTE;
      rtPrev_reg <= `RST_BYTE;
    end
    else if (ce)
    begin
      if (wrEnable)
        chanEnable_reg <= wb_dat_i[`CHAN_FIELD];
      if (wrMask)
        irqMask_reg <= wbLo;
      pending_reg <= pending_next;
      rtPrev_reg <= realTimeIn;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per-channel registers, written only where enabled

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int c = 0; c < CHANS; c++)
      begin
        pinDir_reg[c] <= `RST_PINS;
        pinData_reg[c] <= `RST_PINS;
        opFunc_reg[c] <= `RST_BYTE;
        opCond_reg[c] <= `RST_BYTE;
        txCoef_reg[c] <= `TX_GAIN_ROM;
        rxCoef_reg[c] <= `RX_GAIN_ROM;
      end
    end
    else if (ce)
    begin
      for (int c = 0; c < CHANS; c++)
      begin
        if (chanEnable_reg[c])
        begin
          // status and reserved bits are dropped on write
          if (wrDir && laneLo)
            pinDir_reg[c] <= wbLo[`PIN_FIELD];
          if (wrData && laneLo)
            pinData_reg[c] <= wbLo[`PIN_FIELD];
          if (wrFunc && laneLo)
            opFunc_reg[c] <= wbLo;
          if (wrCond && laneLo)
            opCond_reg[c] <= wbLo;
          if (wrTx && laneLo)
            txCoef_reg[c][`LOW_BYTE] <= wbLo;
          if (wrTx && laneHi)
            txCoef_reg[c][`HIGH_BYTE] <= wbHi;
          if (wrRx && laneLo)
            rxCoef_reg[c][`LOW_BYTE] <= wbLo;
          if (wrRx && laneHi)
            rxCoef_reg[c][`HIGH_BYTE] <= wbHi;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per-channel decoded outputs

  logic [19:0] pinOut_next;
  logic [19:0] pinOeN_next;
  logic [63:0] txCoef_next;
  logic [63:0] rxCoef_next;
  logic [15:0] txSign_next;
  logic [15:0] rxSign_next;

  genvar g, p;
  generate
    for (g = 0; g < CHANS; g++)
    begin : g_chan
      // built-in defaults stay fixed; programmed words untouched
      assign txCoef_next[g*COEF_W +: COEF_W] =
        opFunc_reg[g][`OF_TXG] ? txCoef_reg[g] : `TX_GAIN_ROM;
      assign rxCoef_next[g*COEF_W +: COEF_W] =
        opFunc_reg[g][`OF_RXG] ? rxCoef_reg[g] : `RX_GAIN_ROM;
      assign txSign_next[g*SIGNS +: SIGNS] =
        signsOf(txCoef_next[g*COEF_W +: COEF_W]);
      assign rxSign_next[g*SIGNS +: SIGNS] =
        signsOf(rxCoef_next[g*COEF_W +: COEF_W]);
      for (p = 0; p < LINE_PINS; p++)
      begin : g_pin
        // pins missing on this variant stay released
        if (p < PINS_AVAIL)
        begin : g_fit
          assign pinOeN_next[g*LINE_PINS+p] = !pinDir_reg[g][p];
          assign pinOut_next[g*LINE_PINS+p] = pinData_reg[g][p];
        end
        else
        begin : g_absent
          assign pinOeN_next[g*LINE_PINS+p] = 1'b1;
          assign pinOut_next[g*LINE_PINS+p] = 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lineIoOut <= '0;
      lineIoOeN <= '1;
      inputChangeIrqN <= 1'b1;
      txGainCoef <= {CHANS{`TX_GAIN_ROM}};
      rxGainCoef <= {CHANS{`RX_GAIN_ROM}};
      txGainSignNeg <= {CHANS{signsOf(`TX_GAIN_ROM)}};
      rxGainSignNeg <= {CHANS{signsOf(`RX_GAIN_ROM)}};
    end
    else if (ce)
    begin
      lineIoOut <= pinOut_next;
      lineIoOeN <= pinOeN_next;
      inputChangeIrqN <= ~|pending_next;
      txGainCoef <= txCoef_next;
      rxGainCoef <= rxCoef_next;
      txGainSignNeg <= txSign_next;
      rxGainSignNeg <= rxSign_next;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      linearCoding <= '0;
      muLawCoding <= '0;
      rxGainSrc <= '0;
      txGainSrc <= '0;
      transmitEqSrc <= '0;
      receiveEqSrc <= '0;
      impedanceSrc <= '0;
      balanceSrc <= '0;
      balanceFilterEn <= '1;
      txPathCutoff <= '0;
      rxPathCutoff <= '0;
      txHighpassBypass <= '0;
      rxExtraLoss <= '0;
      txIrqArm <= '0;
      slotLoopback <= '0;
      digitalLoopback <= '0;
      rxTestTone <= '0;
    end
    else if (ce)
    begin
      for (int c = 0; c < CHANS; c++)
      begin
        linearCoding[c] <= opFunc_reg[c][`OF_LINEAR];
        muLawCoding[c] <= opFunc_reg[c][`OF_MULAW];
        rxGainSrc[c] <= opFunc_reg[c][`OF_RXG];
        txGainSrc[c] <= opFunc_reg[c][`OF_TXG];
        transmitEqSrc[c] <= opFunc_reg[c][`OF_XEQ];
        receiveEqSrc[c] <= opFunc_reg[c][`OF_REQ];
        impedanceSrc[c] <= opFunc_reg[c][`OF_IMP];
        balanceSrc[c] <= opFunc_reg[c][`OF_BAL];
        balanceFilterEn[c] <= !opCond_reg[c][`OC_RX_CUT];
        txPathCutoff[c] <= opCond_reg[c][`OC_TX_CUT];
        rxPathCutoff[c] <= opCond_reg[c][`OC_RX_CUT];
        txHighpassBypass[c] <= opCond_reg[c][`OC_HPF_BYP];
        rxExtraLoss[c] <= opCond_reg[c][`OC_RX_LOSS];
        txIrqArm[c] <= opCond_reg[c][`OC_TX_ARM];
        slotLoopback[c] <= opCond_reg[c][`OC_SLOT_LB];
        digitalLoopback[c] <= opCond_reg[c][`OC_DIG_LB];
        rxTestTone[c] <= opCond_reg[c][`OC_TONE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  chk_dir_write: assert property (
    (wrDir && laneLo && chanEnable_reg[0])
      |=> pinDir_reg[0] == $past(wbLo[`PIN_FIELD]))
    else $error("direction write lost");

  chk_pin_drive: assert property (
    ce |=> lineIoOeN[0] == !$past(pinDir_reg[0][0])
           && lineIoOut[0] == $past(pinData_reg[0][0]))
    else $error("pin enable does not follow direction");

  chk_status_read: assert property (
    (rdStrobe && wbIdx == `IDX_PIN_DIR)
      |=> wb_ack_o && wb_dat_o[`DIR_FSL_BIT] == $past(frameSyncLost))
    else $error("frame sync lost bit misreported");

  chk_mask_quiet: assert property (
    (ce && pending_reg == `RST_BYTE
        && ((realTimeIn ^ rtPrev_reg) & ~irqMask_reg) == `RST_BYTE)
      |=> inputChangeIrqN)
    else $error("interrupt without unmasked change");

  chk_mask_global: assert property (
    (wrMask && chanEnable_reg == 4'h0)
      |=> irqMask_reg == $past(wbLo))
    else $error("mask write blocked by channel enables");

  chk_bal_cutoff: assert property (
    ce |=> balanceFilterEn[0] == !$past(opCond_reg[0][`OC_RX_CUT]))
    else $error("balance filter active in receive cutoff");

  chk_revision_read: assert property (
    rdStrobe && wbIdx == `IDX_REVISION
      |=> wb_dat_o[`LOW_BYTE] == REVISION_CODE ##1 !wb_ack_o)
    else $error("revision read wrong");

  chk_gain_source: assert property (
    ce |=> txGainCoef[`COEF_RANGE] ==
      ($past(opFunc_reg[0][`OF_TXG]) ? $past(txCoef_reg[0])
                                     : `TX_GAIN_ROM))
    else $error("gain source select wrong");

  chk_disabled_hold: assert property (
    (wrCond && !chanEnable_reg[0]) |=> $stable(opCond_reg[0]))
    else $error("disabled channel took a command");

  chk_tone_out: assert property (
    ce |=> rxTestTone[0] == $past(opCond_reg[0][`OC_TONE]))
    else $error("test tone does not follow control");

endmodule : codec_channel_control_regs

//--- tb/host_bus_model.sv
// host side of the register bus: a classic Wishbone master
// assumes one clock, the slave answers with a one-cycle ack
`timescale 1ns/1ps

module host_bus_model
(
  input wire logic core_clk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [9:0] adr,
  output logic [3:0] sel,
  output logic [31:0] datW,
  input wire logic [31:0] datR,
  input wire logic ack
);
  initial
  begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 10'h000;
    sel = 4'h0;
    datW = 32'h0000_0000;
  end

  // one bus cycle; held until ack, then adr and datW are left at inverted values
  task automatic access(input logic wr, input logic [7:0] idx,
                        input logic [3:0] s, input logic [31:0] wd,
                        output logic [31:0] rd);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'b00};
    sel <= s;
    datW <= wd;
    do @(posedge core_clk); while (ack !== 1'b1);
    rd = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= ~{idx, 2'b00};
    datW <= ~wd;
  endtask : access
endmodule : host_bus_model

//--- tb/codec_channel_control_regs_tb.sv
// self-checking bench of the codec channel control bank
// assumes the host model drives the bus; ce dropped once while idle
`timescale 1ns/1ps
`include "codec_ctrl_cfg.svh"

`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin errTotal++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module codec_channel_control_regs_tb;
  // value is arbitrary
  localparam logic [7:0] REV = 8'h5A;
  logic core_clk, nrst, ce, cyc, stb, we, ack, frameSyncLost, irqN;
  logic [9:0] adr;
  logic [3:0] sel, channelActive, balanceFilterEn;
  logic [31:0] datW, datR;
  logic [7:0] realTimeIn;
  logic [19:0] lineIoOut, lineIoOeN;
  logic [3:0] linC, muC, rxS, txS, xS, rS, zS, bS;
  logic [3:0] txCut, rxCut, tx_highpass_bypass, loss, arm, slb, dlb, tone;
  logic [63:0] txGainCoef, rxGainCoef;
  logic [15:0] txGainSignNeg, rxGainSignNeg;
  int errTotal = 0;
  int checkCount = 0;
  wire logic [7:0] condBits = {txCut[0], rxCut[0], tx_highpass_bypass[0], loss[0],
                               arm[0], slb[0], dlb[0], tone[0]};
  wire logic [7:0] funcBits = {linC[0], muC[0], rxS[0], txS[0],
                               xS[0], rS[0], zS[0], bS[0]};

  codec_channel_control_regs #(.PINS_AVAIL(3), .REVISION_CODE(REV))
  u_codec_channel_control_regs
  (
    .core_clk(core_clk), .nrst(nrst), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack),
    .channelActive(channelActive), .frameSyncLost(frameSyncLost),
    .realTimeIn(realTimeIn), .lineIoIn(20'h0_0000),
    .lineIoOut(lineIoOut), .lineIoOeN(lineIoOeN),
    .inputChangeIrqN(irqN), .linearCoding(linC), .muLawCoding(muC),
    .rxGainSrc(rxS), .txGainSrc(txS), .transmitEqSrc(xS),
    .receiveEqSrc(rS), .impedanceSrc(zS), .balanceSrc(bS),
    .balanceFilterEn(balanceFilterEn), .txPathCutoff(txCut),
    .rxPathCutoff(rxCut), .txHighpassBypass(tx_highpass_bypass), .rxExtraLoss(loss),
    .txIrqArm(arm), .slotLoopback(slb), .digitalLoopback(dlb),
    .rxTestTone(tone), .txGainCoef(txGainCoef), .rxGainCoef(rxGainCoef),
    .txGainSignNeg(txGainSignNeg), .rxGainSignNeg(rxGainSignNeg)
  );

  host_bus_model u_host_bus_model
  (
    .core_clk(core_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .datW(datW), .datR(datR), .ack(ack)
  );

  ////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] idx, input logic [15:0] d,
                    input logic [3:0] s = 4'b0011);
    logic [31:0] rd;
    u_host_bus_model.access(1'b1, idx, s, {16'h0000, d}, rd);
  endtask : wr

  task automatic rdchk(input logic [7:0] idx, input logic [15:0] e);
    logic [31:0] rd;
    u_host_bus_model.access(1'b0, idx, 4'b0011, 32'h0000_0000, rd);
    `CHK(rd[15:0], e)
  endtask : rdchk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    errTotal++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end

  logic [7:0] rIdx [7] = '{`IDX_PIN_DIR, `IDX_OP_FUNC, `IDX_IRQ_MASK,
    `IDX_OP_COND, `IDX_REVISION, `IDX_TX_GAIN, `IDX_RX_GAIN};
  logic [15:0] rExp [7] = '{16'h0000, 16'h0000, 16'h00FF, 16'h0000,
    {8'h00, REV}, 16'hA9F0, 16'h23A1};

  initial
  begin
    nrst = 1'b0;
    ce = 1'b1;
    channelActive = 4'h0;
    frameSyncLost = 1'b0;
    realTimeIn = 8'h00;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    `CHK(lineIoOeN, 20'hF_FFFF)
    `CHK(balanceFilterEn, 4'hF)
    for (int i = 0; i < 7; i++)
      rdchk(rIdx[i], rExp[i]);
    // pins: one, two, four, five out; three in; four and five absent
    @(posedge core_clk);
    channelActive <= 4'b0001;
    frameSyncLost <= 1'b1;
    wr(`IDX_PIN_DIR, 16'h001B, 4'b0001);
    wr(`IDX_PIN_DATA, 16'h001F, 4'b0001);
    @(negedge core_clk);
    `CHK(lineIoOeN[4:0], 5'b11100)
    `CHK(lineIoOeN[19:15], 5'b11100)
    `CHK(lineIoOut[2], 1'b1)
    rdchk(`IDX_PIN_DIR, 16'h007B);
    rdchk(`IDX_PIN_DATA, 16'h001B);
    // only channel two takes channel commands
    wr(`IDX_CHAN_EN, 16'h0002, 4'b0001);
    wr(`IDX_OP_COND, 16'h00FF, 4'b0001);
    @(negedge core_clk);
    `CHK(txCut, 4'b0010)
    rdchk(`IDX_OP_COND, 16'h00FF);
    wr(`IDX_CHAN_EN, 16'h0000, 4'b0001);
    rdchk(`IDX_PIN_DIR, 16'h0020);
    wr(`IDX_IRQ_MASK, 16'h00FE, 4'b0001);
    rdchk(`IDX_IRQ_MASK, 16'h00FE);
    rdchk(`IDX_REVISION, {8'h00, REV});
    wr(`IDX_CHAN_EN, 16'h000F, 4'b0001);
    for (int b = 0; b < 8; b++)
    begin
      wr(`IDX_OP_COND, 16'(1 << b), 4'b0001);
      wr(`IDX_OP_FUNC, 16'(1 << b), 4'b0001);
      @(negedge core_clk);
      `CHK(condBits, 8'(1 << b))
      `CHK(balanceFilterEn[0], (b != 6))
      `CHK(funcBits, 8'(1 << b))
    end
    wr(`IDX_OP_COND, 16'h0000, 4'b0001);
    // programmed against built-in gain words
    wr(`IDX_TX_GAIN, 16'h8888);
    wr(`IDX_RX_GAIN, 16'h0800, 4'b0010);
    wr(`IDX_OP_FUNC, 16'h0030, 4'b0001);
    @(negedge core_clk);
    `CHK(txGainCoef[15:0], 16'h8888)
    `CHK(txGainSignNeg[3:0], 4'hF)
    `CHK(rxGainCoef[15:0], 16'h08A1)
    `CHK(rxGainSignNeg[3:0], 4'b0110)
    wr(`IDX_OP_FUNC, 16'h0000, 4'b0001);
    @(negedge core_clk);
    `CHK(txGainCoef[15:0], 16'hA9F0)
    `CHK(txGainSignNeg[3:0], 4'b1110)
    rdchk(`IDX_TX_GAIN, 16'h8888);
    // masked change first, then an unmasked one
    @(posedge core_clk);
    realTimeIn <= 8'h02;
    repeat (3) @(negedge core_clk);
    `CHK(irqN, 1'b1)
    @(posedge core_clk);
    realTimeIn <= 8'h03;
    repeat (3) @(negedge core_clk);
    `CHK(irqN, 1'b0)
    rdchk(`IDX_RT_CLEAR, 16'h0003);
    @(negedge core_clk);
    `CHK(irqN, 1'b1)
    // frozen while ce is low, then the held change shows
    @(posedge core_clk);
    ce <= 1'b0;
    realTimeIn <= 8'h02;
    repeat (3) @(negedge core_clk);
    `CHK(irqN, 1'b1)
    @(posedge core_clk);
    ce <= 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK(irqN, 1'b0)
    rdchk(`IDX_RT_PEEK, 16'h0002);
    @(negedge core_clk);
    `CHK(irqN, 1'b0)
    rdchk(`IDX_RT_CLEAR, 16'h0002);
    @(negedge core_clk);
    `CHK(irqN, 1'b1)
    // mid-run reset brings the registers back
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rdchk(`IDX_IRQ_MASK, 16'h00FF);
    rdchk(`IDX_TX_GAIN, 16'hA9F0);
    rdchk(`IDX_PIN_DIR, 16'h0060);
    @(negedge core_clk);
    `CHK(irqN, 1'b1)
    rdchk(8'hFF, 16'h0000);
    tally_and_finish();
  end
endmodule : codec_channel_control_regs_tb
